// [shared/uam_pkg.sv]
// Package of register map, field layout and constants for the address match block
package uam_pkg;

	localparam int          UAM_DATA_W       = 32;
	localparam int          UAM_ADDR_W       = 12;
	localparam int          UAM_CHAR_W       = 8;

	localparam logic [11:0] UAM_OFF_MATCH    = 12'h000;
	localparam logic [11:0] UAM_OFF_RXWORD   = 12'h004;
	localparam logic [11:0] UAM_OFF_CTRL     = 12'h008;
	localparam logic [11:0] UAM_OFF_STATUS   = 12'h00C;

	localparam int          UAM_ADDR_LSB     = 0;
	localparam int          UAM_MASK_LSB     = 8;
	localparam int          UAM_NINTH_POS    = 8;

	localparam int          UAM_CTRL_ADDRESS_DETECT_ON   = 0;
	localparam int          UAM_CTRL_NINE    = 1;

	localparam int          UAM_ST_ADDR_MODE = 0;
	localparam int          UAM_ST_LAST_HIT  = 1;
	localparam int          UAM_ST_HUNT      = 2;

	localparam logic [15:0] UAM_MATCH_RST    = 16'h0000;
	localparam logic [8:0]  UAM_RXWORD_RST   = 9'h000;
	localparam logic [1:0]  UAM_CTRL_RST     = 2'h0;

	typedef enum logic [1:0] {
		UAM_IDLE   = 2'b00,
		UAM_SETUP  = 2'b01,
		UAM_ACCESS = 2'b11
	} uam_apb_t;

endpackage : uam_pkg

// [design/uam_compare.sv]
// Masked address comparator for one received character
`timescale 1ns/1ps
module uam_compare
	import uam_pkg::*;
#(
	parameter int W = UAM_CHAR_W
) (
	input  wire logic [W-1:0] rx_low_byte,
	input  wire logic         rx_ninth_bit,
	input  wire logic [W-1:0] match_address_value,
	input  wire logic [W-1:0] match_bit_select,
	input  wire logic         address_mode,
	output logic              is_address,
	output logic              hit
);

	always_comb begin
		is_address = rx_ninth_bit; // (RQ7)
		// Only selected bits may differ to spoil the match
		hit = address_mode && is_address &&
			(((rx_low_byte ^ match_address_value) & match_bit_select) == '0); // (RQ1)
	end

endmodule : uam_compare

// [design/uam_top.sv]
// APB register slave with hardware address match and receive data word
// What this block does, and what software must do (RQ5, RQ6)
// (RQ1) Mask bit one includes the matching address bit; zero excludes it.
// (RQ2) Hold 8-bit match address in low byte; compare in hardware.
// (RQ3) Comparison acts only in address detect mode, no effect otherwise.
// (RQ4) Receive word bits fifteen to nine always read zero.
// (RQ5) Software waits one cycle after transmit write before reading empty flag.
// (RQ6) Software sets module enable before transmitter enable.
// (RQ7) A character with ninth bit one is an address character.
// (RQ8) Address detect enable has no effect unless 9-bit characters chosen.
// (RQ9) Receive word: ninth bit at eight, low byte below, reset zero.
`timescale 1ns/1ps
module uam_top
	import uam_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [UAM_ADDR_W-1:0] paddr,
	input  wire logic [UAM_DATA_W-1:0] pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [UAM_DATA_W-1:0] prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  rx_valid,
	input  wire logic [7:0]            rx_low_byte,
	input  wire logic                  rx_ninth_bit,
	output logic                       rx_accept,
	output logic                       addr_hit
);

	typedef struct packed {
		logic [UAM_CHAR_W-1:0]  mask;
		logic [UAM_CHAR_W-1:0]  addr;
		logic [UAM_NINTH_POS:0] rxword;
		logic                  address_detect_on;
		logic                  nine;
		logic                  hunt;
		logic                  last_hit;
		logic                  accept;
		logic                  hitp;
		logic [UAM_DATA_W-1:0] rdata;
	} uam_state_t;

	uam_state_t st_r;
	uam_state_t st_nxt;
	logic       addr_mode;
	logic       is_addr;
	logic       hit;
	logic       acc;
	logic       wr;
	logic       mapped;

	function automatic logic is_mapped(input logic [UAM_ADDR_W-1:0] a);
		is_mapped = (a == UAM_OFF_MATCH) || (a == UAM_OFF_RXWORD) ||
			(a == UAM_OFF_CTRL) || (a == UAM_OFF_STATUS);
	endfunction : is_mapped

	// Stored word layout, ninth bit on top
	function automatic logic [UAM_NINTH_POS:0] pack_word(
		input logic                  ninth,
		input logic [UAM_CHAR_W-1:0] low
	);
		pack_word = {ninth, low}; // (RQ9)
	endfunction : pack_word

	// Byte lane update; lanes without strobe keep the old value
	function automatic logic [UAM_CHAR_W-1:0] lane_pick(
		input logic                  en,
		input logic [UAM_CHAR_W-1:0] new_v,
		input logic [UAM_CHAR_W-1:0] old_v
	);
		lane_pick = en ? new_v : old_v;
	endfunction : lane_pick

	// Read view of one register; unimplemented bits stay zero
	function automatic logic [UAM_DATA_W-1:0] read_view(
		input logic [UAM_ADDR_W-1:0] a,
		input uam_state_t            s,
		input logic                  mode
	);
		logic [UAM_DATA_W-1:0] v;
		v = '0;
		if (a == UAM_OFF_MATCH) begin
			v[UAM_ADDR_LSB +: UAM_CHAR_W] = s.addr;
			v[UAM_MASK_LSB +: UAM_CHAR_W] = s.mask;
		end else if (a == UAM_OFF_RXWORD) begin
			v[UAM_NINTH_POS:0] = s.rxword; // (RQ4)
		end else if (a == UAM_OFF_CTRL) begin
			v[UAM_CTRL_ADDRESS_DETECT_ON] = s.address_detect_on;
			v[UAM_CTRL_NINE]  = s.nine;
		end else if (a == UAM_OFF_STATUS) begin
			v[UAM_ST_ADDR_MODE] = mode;
			v[UAM_ST_LAST_HIT]  = s.last_hit;
			v[UAM_ST_HUNT]      = s.hunt;
		end
		read_view = v;
	endfunction : read_view

	// Address detect gated by 9-bit mode
	assign addr_mode = st_r.address_detect_on && st_r.nine; // (RQ8)

	uam_compare #(
		.W(UAM_CHAR_W)
	) u_cmp (
		.rx_low_byte        (rx_low_byte),
		.rx_ninth_bit       (rx_ninth_bit),
		.match_address_value(st_r.addr),
		.match_bit_select   (st_r.mask),
		.address_mode       (addr_mode),
		.is_address         (is_addr),
		.hit                (hit)
	);

	assign acc     = psel && penable;
	assign wr      = acc && pwrite;
	assign mapped  = is_mapped(paddr);
	assign pready  = 1'b1;
	assign prdata  = st_r.rdata;
	assign pslverr = acc && !mapped;
	assign rx_accept = st_r.accept;
	assign addr_hit  = st_r.hitp;

	always_comb begin
		st_nxt          = st_r;
		st_nxt.accept   = 1'b0;
		st_nxt.hitp     = 1'b0;

		// Register writes; byte strobes honoured per lane
		if (wr && paddr == UAM_OFF_MATCH) begin
			st_nxt.addr = lane_pick(pstrb[0], pwdata[UAM_ADDR_LSB +: UAM_CHAR_W], st_r.addr); // (RQ2)
			st_nxt.mask = lane_pick(pstrb[1], pwdata[UAM_MASK_LSB +: UAM_CHAR_W], st_r.mask); // (RQ1)
		end else if (wr && paddr == UAM_OFF_CTRL) begin
			if (pstrb[0]) begin
				st_nxt.address_detect_on = pwdata[UAM_CTRL_ADDRESS_DETECT_ON];
				st_nxt.nine  = pwdata[UAM_CTRL_NINE];
			end
		end

		// Hunting only means something inside address mode
		if (!addr_mode) begin
			st_nxt.hunt = 1'b0;
		end

		// Character handling
		if (rx_valid) begin
			if (!addr_mode) begin
				st_nxt.accept = 1'b1; // (RQ3)
				st_nxt.rxword = pack_word(rx_ninth_bit, rx_low_byte);
			end else if (is_addr) begin
				// Matching address opens the gate for following data
				st_nxt.last_hit = hit;
				st_nxt.hitp     = hit;
				st_nxt.hunt     = !hit;
				if (hit) begin
					st_nxt.accept = 1'b1;
					st_nxt.rxword = pack_word(rx_ninth_bit, rx_low_byte);
				end
			end else if (!st_r.hunt) begin
				// Data after a hit passes; data while hunting is dropped
				st_nxt.accept = 1'b1;
				st_nxt.rxword = pack_word(rx_ninth_bit, rx_low_byte);
			end
		end

		// Read data registered at setup so it is valid in access phase
		if (psel && !penable && !pwrite) begin
			st_nxt.rdata = read_view(paddr, st_r, addr_mode);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.mask     <= UAM_MATCH_RST[15:8];
			st_r.addr     <= UAM_MATCH_RST[7:0];
			st_r.rxword   <= UAM_RXWORD_RST; // (RQ9)
			st_r.address_detect_on    <= UAM_CTRL_RST[UAM_CTRL_ADDRESS_DETECT_ON];
			st_r.nine     <= UAM_CTRL_RST[UAM_CTRL_NINE];
			st_r.hunt     <= 1'b0;
			st_r.last_hit <= 1'b0;
			st_r.accept   <= 1'b0;
			st_r.hitp     <= 1'b0;
			st_r.rdata    <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule : uam_top

// [tb/uam_properties.sv]
// Port assertions for the address match block
`timescale 1ns/1ps
module uam_properties import uam_pkg::*; (
	input wire logic pclk, presetn, psel, penable, pwrite, rx_valid, rx_ninth_bit,
	input wire logic rx_accept, addr_hit,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [7:0] rx_low_byte);
	// Shadow of control and match registers, taken from bus writes
	logic [17:0] s_r;
	wire wr = psel && penable && pwrite;
	wire eq = ((rx_low_byte ^ s_r[7:0]) & s_r[15:8]) == 8'h00;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) s_r <= 18'h0;
		else if (wr && paddr == UAM_OFF_MATCH) s_r[15:0] <= pwdata[15:0];
		else if (wr && paddr == UAM_OFF_CTRL) s_r[17:16] <= pwdata[1:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_mask; addr_hit |-> $past(eq); endproperty
	a_mask: assert property (p_mask) else $error("hit, no match");
	property p_hit; rx_valid && rx_ninth_bit && s_r[17:16] == 2'h3 && eq |=> addr_hit; endproperty
	a_hit: assert property (p_hit) else $error("match missed");
	property p_off; rx_valid && !s_r[16] |=> rx_accept; endproperty
	a_off: assert property (p_off) else $error("drop, detect off");
	property p_nine; rx_valid && s_r[17:16] == 2'h1 |=> rx_accept; endproperty
	a_nine: assert property (p_nine) else $error("drop, 8-bit");
	property p_pad; penable && !pwrite && paddr == UAM_OFF_RXWORD |-> prdata[31:9] == 23'h0;
	endproperty
	a_pad: assert property (p_pad) else $error("word pad");
	property p_kind; addr_hit |-> $past(rx_valid && rx_ninth_bit); endproperty
	a_kind: assert property (p_kind) else $error("hit on data");
	property p_acc; rx_accept |-> $past(rx_valid); endproperty
	a_acc: assert property (p_acc) else $error("stray accept");
	c_hit: cover property (addr_hit);
	c_acc: cover property (rx_accept);
	c_drop: cover property (rx_valid && s_r[17:16] == 2'h3 ##1 !rx_accept);
endmodule : uam_properties
bind uam_top uam_properties u_props (.*);

// [tb/uam_node.sv]
// Remote sender model
`timescale 1ns/1ps
module uam_node (input wire logic pclk, output logic rx_valid = 1'b0,
	output logic rx_ninth_bit = 1'b0, output logic [7:0] rx_low_byte = 8'h00);
	task automatic send(input logic nb, input logic [7:0] b);
		@(posedge pclk) {rx_valid, rx_ninth_bit, rx_low_byte} <= {1'b1, nb, b};
		// Inverse after release, so a stale char never passes
		@(posedge pclk) {rx_valid, rx_ninth_bit, rx_low_byte} <= {1'b0, ~nb, ~b};
	endtask : send
endmodule : uam_node

// [tb/tb_top.sv]
// Self-checking bench for the address match block
`timescale 1ns/1ps
module tb_top import uam_pkg::*; ;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, rx_valid, rx_ninth_bit, rx_accept, addr_hit;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [7:0] rx_low_byte;
	logic [3:0] pstrb = 4'hF;
	int n_fail = 0, tests_run = 0;
	always #20 pclk = ~pclk;
	uam_node node (.*);
	uam_top dut (.*);
	task automatic chk(input string nm, input logic [31:0] s, x);
		tests_run++;
		n_fail += (s !== x);
		if (s !== x) $display("Error %s expected %h seen %h", nm, x, s);
	endtask : chk
	task automatic close_out();
		$display("checks %0d errors %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
		chk("pready", pready, 1'b1);
		if (pready !== 1'b1) close_out();
		chk("pslverr", pslverr, a > 12'h00C);
		if (!w) chk("prdata", prdata, d);
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rx(input logic nb, input logic [7:0] b, input logic acc);
		node.send(nb, b);
		#1 chk("rx_accept", rx_accept, acc);
	endtask : rx
	task automatic t_regs();
		apb(1'b0, UAM_OFF_RXWORD, 32'h0);
		apb(1'b1, UAM_OFF_MATCH, 32'hF0A5);
		apb(1'b0, UAM_OFF_MATCH, 32'hF0A5);
		apb(1'b0, 12'h010, 32'h0);
	endtask : t_regs
	task automatic t_rx();
		rx(1'b1, 8'h3C, 1'b1);
		apb(1'b1, UAM_OFF_CTRL, 32'h1);
		rx(1'b1, 8'hC3, 1'b1);
		apb(1'b0, UAM_OFF_RXWORD, 32'h1C3);
		apb(1'b1, UAM_OFF_CTRL, 32'h3);
		rx(1'b1, 8'hA3, 1'b1);
		chk("addr_hit", addr_hit, 1'b1);
		rx(1'b0, 8'h55, 1'b1);
		rx(1'b1, 8'h35, 1'b0);
		chk("addr_hit", addr_hit, 1'b0);
		rx(1'b0, 8'h11, 1'b0);
		apb(1'b0, UAM_OFF_RXWORD, 32'h55);
	endtask : t_rx
	task automatic t_more();
		apb(1'b0, UAM_OFF_CTRL, 32'h3);
		apb(1'b0, UAM_OFF_STATUS, 32'h5);
		apb(1'b1, UAM_OFF_MATCH, 32'h00A5);
		rx(1'b1, 8'h00, 1'b1);
		chk("addr_hit", addr_hit, 1'b1);
		apb(1'b0, UAM_OFF_STATUS, 32'h3);
		@(posedge pclk) presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk("prdata", prdata, 32'h0);
		apb(1'b0, UAM_OFF_MATCH, 32'h0);
		apb(1'b0, UAM_OFF_STATUS, 32'h0);
		rx(1'b1, 8'h35, 1'b1);
	endtask : t_more
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_rx();
		t_more();
		close_out();
	end
endmodule : tb_top
